// >>> rtl/ssoc_special_ctrl.v
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01: Input-sourced enable switch ignores the bus bit
// RULE_02: No input assigned: bus bit activates switch; code takes the bus bit only with source 8'h0D, not with source 0
// RULE_03: Switch in special or repair mode overrides stops
// RULE_04: Switch taking effect cancels running stop timers
// RULE_05: Assigned safe input ON activates the switch
// RULE_06: Indications routable to output one, 0/1/2
// RULE_07: Repair keeps only chosen stop and switch
// RULE_08: Repair stop code 0 torque off, 1 stop one
// RULE_09: Repair entry disables speed, position, clears homing
// RULE_10: Assigned safe input ON requests repair mode
// RULE_11: Bus requests repair only without input source; code takes the bus bit only with source 8'h0D, not with source 0
// RULE_12: Mismatch after repair exit raises errors, clears homing
// RULE_13: Homing state codes 0 to 3
// RULE_14: Cascade source must be input four, code 4
// RULE_15: Input four delay at most 10 ms
// RULE_16: Restart after torque off must be acknowledged
// RULE_17: Cascading inhibits bus control of output one
// RULE_18: Cascading with special operation needs stop two
// RULE_19: Torque off triggers cascade, switch cannot
// RULE_20: Measure ms from output off to input off
// RULE_21: Stop triggered via cascade reads zero ms
// RULE_22: Delay holds until next system acknowledgement
// RULE_23: Delay counts per ms tick, saturates
`include "ssoc_consts.vh"

module ssoc_special_ctrl #(
    parameter TICK_CYCLES = `SSOC_CLK_HZ / `SSOC_MS_PER_S * `SSOC_TICK_MS
) (
    input wire clk,
    input wire rst,
    // Avalon-MM slave, byte address
    input wire [15:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    output wire [31:0] readdata,
    output wire waitrequest,
    // Safe input states from the pins, ON is high
    input wire [3:0] safe_input_on,
    // Safety-bus telegram content, same clock
    input wire bus_enable_switch,
    input wire bus_repair_mode,
    input wire bus_safe_output_1,
    // Surrounding safety logic, same clock
    input wire special_op_active,
    input wire safe_torque_off_req,
    input wire system_ack,
    input wire abs_pos_monitor_on,
    input wire encoder_mismatch,
    input wire homing_update,
    input wire [1:0] homing_value,
    // Results
    output wire enable_switch_active,
    output wire repair_mode_active,
    output wire stop_override,
    output wire stop_timer_cancel,
    output wire repair_stop_sto,
    output wire repair_stop_ss1,
    output wire monitoring_disable,
    output wire cascade_stop,
    output wire [15:0] cascade_delay,
    output wire [1:0] homing_state,
    output wire pos_window_error,
    output wire slip_error,
    output reg safe_output_1
);

    // ==========================================================
    // Register file
    reg [7:0] cas_src_r;
    reg [7:0] es_src_r;
    reg [7:0] es_out_r;
    reg [7:0] rms_src_r;
    reg [7:0] rms_out_r;
    reg [7:0] hom_restart_r;
    reg [15:0] hom_tol_r;
    reg [7:0] rms_stop_r;
    reg ack_r;
    reg [31:0] rdata_r;
    reg [31:0] rdata_nxt;
    wire [13:0] idx;
    wire req;
    wire wr_do;

    // ==========================================================
    // Synchronisers and state
    reg [3:0] in_s1_r;
    reg [3:0] in_s2_r;
    reg es_eff_r;
    reg rms_r;
    reg [1:0] hom_r;
    reg poswin_r;
    reg slip_r;
    reg post_exit_r;
    reg cas_stop_r;
    reg cas_cnt_r;
    reg cas_done_r;
    reg cas_arm_r;
    reg [15:0] delay_r;
    reg [31:0] tick_r;
    reg es_sel;
    reg rms_sel;
    wire es_on;
    wire rms_on;
    wire es_eff;
    wire cas_cfg;
    wire in4_off;
    wire tick;
    reg ind_es;
    reg ind_rms;

    // One wait state: request seen, then answered next edge
    assign req = read | write;
    assign waitrequest = req & ~ack_r;
    assign wr_do = write & ack_r;
    assign idx = address[15:2];
    assign readdata = rdata_r;

    // Read mux, unmapped indices read as zero
    always @* begin
        rdata_nxt = 32'h0000_0000;
        case (idx)
            `SSOC_IDX_CAS_SRC: rdata_nxt[7:0] = cas_src_r;
            `SSOC_IDX_ES_SRC: rdata_nxt[7:0] = es_src_r;
            `SSOC_IDX_ES_OUT: rdata_nxt[7:0] = es_out_r;
            `SSOC_IDX_RMS_SRC: rdata_nxt[7:0] = rms_src_r;
            `SSOC_IDX_RMS_OUT: rdata_nxt[7:0] = rms_out_r;
            `SSOC_IDX_CAS_DELAY: rdata_nxt[15:0] = delay_r;
            `SSOC_IDX_BUS_CTRL: rdata_nxt[1:0] = {bus_repair_mode, bus_enable_switch};
            `SSOC_IDX_HOM_RESTART: rdata_nxt[7:0] = hom_restart_r;
            `SSOC_IDX_HOM_TOL: rdata_nxt[15:0] = hom_tol_r;
            `SSOC_IDX_HOM_STATE: rdata_nxt[1:0] = hom_r; // see RULE_13
            `SSOC_IDX_RMS_STOP: rdata_nxt[7:0] = rms_stop_r;
            `SSOC_IDX_STATUS: begin
                rdata_nxt[`SSOC_ST_ES] = es_eff_r;
                rdata_nxt[`SSOC_ST_RMS] = rms_r;
                rdata_nxt[`SSOC_ST_POSWIN] = poswin_r;
                rdata_nxt[`SSOC_ST_SLIP] = slip_r;
                rdata_nxt[`SSOC_ST_CAS_CFG] = cas_cfg;
                rdata_nxt[`SSOC_ST_CAS_STOP] = cas_stop_r;
                rdata_nxt[`SSOC_ST_CAS_DONE] = cas_done_r;
            end
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end

    // Bus handshake and configuration writes
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            cas_src_r <= `SSOC_RST_SRC;
            es_src_r <= `SSOC_RST_SRC;
            es_out_r <= `SSOC_RST_OUT;
            rms_src_r <= `SSOC_RST_SRC;
            rms_out_r <= `SSOC_RST_OUT;
            hom_restart_r <= `SSOC_RST_STOP;
            hom_tol_r <= `SSOC_RST_TOL;
            rms_stop_r <= `SSOC_RST_STOP;
        end else begin
            ack_r <= req & ~ack_r;
            if (read & ~ack_r)
                rdata_r <= rdata_nxt;
            if (wr_do) begin
                case (idx)
                    `SSOC_IDX_CAS_SRC: cas_src_r <= writedata[7:0];
                    `SSOC_IDX_ES_SRC: es_src_r <= writedata[7:0];
                    `SSOC_IDX_ES_OUT: es_out_r <= writedata[7:0];
                    `SSOC_IDX_RMS_SRC: rms_src_r <= writedata[7:0];
                    `SSOC_IDX_RMS_OUT: rms_out_r <= writedata[7:0];
                    `SSOC_IDX_HOM_RESTART: hom_restart_r <= writedata[7:0];
                    `SSOC_IDX_HOM_TOL: hom_tol_r <= writedata[15:0];
                    `SSOC_IDX_RMS_STOP: rms_stop_r <= writedata[7:0];
                    default: ;
                endcase
            end
        end
    end

    // ==========================================================
    // Safe input synchroniser, pins are asynchronous
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            in_s1_r <= 4'h0;
            in_s2_r <= 4'h0;
        end else begin
            in_s1_r <= safe_input_on;
            in_s2_r <= in_s1_r;
        end
    end

    // Source selection; the bus bit counts only when the bus is the source
    always @* begin
        es_sel = 1'b0;
        rms_sel = 1'b0;
        if (es_src_r >= `SSOC_SRC_IN1 && es_src_r <= `SSOC_SRC_IN4)
            es_sel = in_s2_r[es_src_r[1:0] - 2'd1]; // see RULE_05 see RULE_01
        else if (es_src_r == `SSOC_SRC_BUS)
            es_sel = bus_enable_switch; // see RULE_02
        if (rms_src_r >= `SSOC_SRC_IN1 && rms_src_r <= `SSOC_SRC_IN4)
            rms_sel = in_s2_r[rms_src_r[1:0] - 2'd1]; // see RULE_10
        else if (rms_src_r == `SSOC_SRC_BUS)
            rms_sel = bus_repair_mode; // see RULE_11
    end
    assign es_on = es_sel;
    assign rms_on = rms_sel;

    // Switch only counts while a special mode is in force
    assign es_eff = es_on & (special_op_active | rms_on); // see RULE_03

    // ==========================================================
    // Repair mode, homing and post-exit checking
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            es_eff_r <= 1'b0;
            rms_r <= 1'b0;
            hom_r <= `SSOC_HOM_NONE;
            poswin_r <= 1'b0;
            slip_r <= 1'b0;
            post_exit_r <= 1'b0;
        end else begin
            es_eff_r <= es_eff;
            rms_r <= rms_on;
            // Exit opens a check window closed by acknowledgement
            if (rms_r & ~rms_on)
                post_exit_r <= 1'b1;
            else if (system_ack | rms_on)
                post_exit_r <= 1'b0;
            // Errors are sticky; a new mismatch beats the acknowledgement
            if (post_exit_r & abs_pos_monitor_on & encoder_mismatch) begin
                poswin_r <= 1'b1; // see RULE_12
                slip_r <= 1'b1;
            end else if (system_ack) begin
                poswin_r <= 1'b0;
                slip_r <= 1'b0;
            end
            // Clearing outranks a homing update so repair cannot keep a reference
            if (rms_on)
                hom_r <= `SSOC_HOM_NONE; // see RULE_09
            else if (post_exit_r & abs_pos_monitor_on & encoder_mismatch)
                hom_r <= `SSOC_HOM_NONE; // see RULE_12
            else if (homing_update)
                hom_r <= homing_value; // see RULE_13
        end
    end

    assign enable_switch_active = es_eff_r;
    assign repair_mode_active = rms_r;
    assign stop_override = es_eff_r; // see RULE_03
    assign stop_timer_cancel = es_eff & ~es_eff_r; // see RULE_04
    // Only the chosen stop stays; ramp and all other monitors drop out
    assign repair_stop_sto = rms_r & (rms_stop_r == `SSOC_STOP_STO); // see RULE_08 see RULE_07
    assign repair_stop_ss1 = rms_r & (rms_stop_r == `SSOC_STOP_SS1); // see RULE_08
    assign monitoring_disable = rms_r; // see RULE_07 see RULE_09
    assign homing_state = hom_r;
    assign pos_window_error = poswin_r;
    assign slip_error = slip_r;

    // ==========================================================
    // Cascading
    assign cas_cfg = (cas_src_r == `SSOC_SRC_IN4);
    assign in4_off = ~in_s2_r[3];
    assign tick = (tick_r == TICK_CYCLES - 1);

    // Millisecond prescaler, restarted when a measurement starts
    always @(posedge clk or posedge rst) begin
        if (rst)
            tick_r <= 32'h0000_0000;
        else if (tick | ~cas_cnt_r)
            tick_r <= 32'h0000_0000;
        else
            tick_r <= tick_r + 32'h0000_0001;
    end

    // Input four must read ON again before a remote OFF counts; otherwise the
    // echo of our own stop would restart the cascade right after acknowledge
    always @(posedge clk or posedge rst) begin
        if (rst)
            cas_arm_r <= 1'b0;
        else if (~in4_off)
            cas_arm_r <= 1'b1;
        else if (cas_stop_r)
            cas_arm_r <= 1'b0;
    end

    // Local torque off starts a stop; switch override does not, see RULE_19
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cas_stop_r <= 1'b0;
            cas_cnt_r <= 1'b0;
            cas_done_r <= 1'b0;
            delay_r <= 16'h0000;
        end else if (~cas_cfg) begin
            cas_stop_r <= 1'b0;
            cas_cnt_r <= 1'b0;
            cas_done_r <= 1'b0;
            delay_r <= 16'h0000;
        end else if (~cas_stop_r & ~cas_done_r & safe_torque_off_req) begin
            cas_stop_r <= 1'b1; // see RULE_19
            cas_cnt_r <= 1'b1;
            delay_r <= 16'h0000;
        end else if (~cas_stop_r & ~cas_done_r & cas_arm_r & in4_off) begin
            cas_stop_r <= 1'b1; // see RULE_21
            cas_done_r <= 1'b1;
            delay_r <= 16'h0000;
        end else if (cas_cnt_r & in4_off) begin
            cas_cnt_r <= 1'b0; // see RULE_20
            cas_done_r <= 1'b1;
        end else if (cas_cnt_r & tick) begin
            if (delay_r != `SSOC_DELAY_MAX)
                delay_r <= delay_r + 16'h0001; // see RULE_23
        end else if (system_ack & cas_done_r) begin
            cas_stop_r <= 1'b0; // see RULE_22
            cas_done_r <= 1'b0;
            delay_r <= 16'h0000;
        end
    end

    assign cascade_stop = cas_stop_r;
    assign cascade_delay = delay_r;

    // ==========================================================
    // Output one routing
    always @* begin
        ind_es = 1'b0;
        ind_rms = 1'b0;
        case (es_out_r)
            `SSOC_OUT_POS: ind_es = es_eff_r; // see RULE_06
            `SSOC_OUT_NEG: ind_es = ~es_eff_r;
            default: ind_es = 1'b0;
        endcase
        case (rms_out_r)
            `SSOC_OUT_POS: ind_rms = rms_r; // see RULE_06
            `SSOC_OUT_NEG: ind_rms = ~rms_r;
            default: ind_rms = 1'b0;
        endcase
    end

    // Cascade owns the pin and locks the bus out of it
    always @(posedge clk or posedge rst) begin
        if (rst)
            safe_output_1 <= 1'b0;
        else if (cas_cfg)
            safe_output_1 <= ~cas_stop_r; // see RULE_17
        else
            safe_output_1 <= ind_es | ind_rms | bus_safe_output_1;
    end

endmodule // ssoc_special_ctrl

// >>> rtl/ssoc_consts.vh
`ifndef SSOC_CONSTS_VH
`define SSOC_CONSTS_VH

// ==========================================================
// Register indices (byte address is four times the index)
`define SSOC_IDX_CAS_SRC      14'h2124
`define SSOC_IDX_ES_SRC       14'h28AE
`define SSOC_IDX_ES_OUT       14'h28AF
`define SSOC_IDX_RMS_SRC      14'h28AB
`define SSOC_IDX_RMS_OUT      14'h28AD
`define SSOC_IDX_CAS_DELAY    14'h2900
`define SSOC_IDX_BUS_CTRL     14'h2901
`define SSOC_IDX_HOM_RESTART  14'h2902
`define SSOC_IDX_HOM_TOL      14'h2903
`define SSOC_IDX_HOM_STATE    14'h2904
`define SSOC_IDX_RMS_STOP     14'h2905
`define SSOC_IDX_STATUS       14'h2906

// ==========================================================
// Source selection codes
`define SSOC_SRC_OFF          8'h00
`define SSOC_SRC_IN1          8'h01
`define SSOC_SRC_IN4          8'h04
`define SSOC_SRC_BUS          8'h0D

// ==========================================================
// Output routing codes
`define SSOC_OUT_OFF          8'h00
`define SSOC_OUT_POS          8'h01
`define SSOC_OUT_NEG          8'h02

// ==========================================================
// Repair stop select codes
`define SSOC_STOP_STO         8'h00
`define SSOC_STOP_SS1         8'h01

// ==========================================================
// Homing state codes
`define SSOC_HOM_NONE         2'h0
`define SSOC_HOM_ACTIVE       2'h1
`define SSOC_HOM_AVAIL        2'h2
`define SSOC_HOM_SMALL        2'h3

// ==========================================================
// Reset values
`define SSOC_RST_SRC          8'h00
`define SSOC_RST_OUT          8'h00
`define SSOC_RST_STOP         8'h00
`define SSOC_RST_TOL          16'h0000

// ==========================================================
// Status register bit positions
`define SSOC_ST_ES            0
`define SSOC_ST_RMS           1
`define SSOC_ST_POSWIN        2
`define SSOC_ST_SLIP          3
`define SSOC_ST_CAS_CFG       4
`define SSOC_ST_CAS_STOP      5
`define SSOC_ST_CAS_DONE      6

// ==========================================================
// Timing
`define SSOC_CLK_HZ           10000000
`define SSOC_MS_PER_S         1000
`define SSOC_TICK_MS          1
`define SSOC_DELAY_MAX        16'hFFFF

`endif

// >>> sim/ssoc_chk.sv
`timescale 1ns/1ps
// ==========================================
// Port checker for the special operation control
module ssoc_chk (
    input wire clk,
    input wire rst,
    input wire read,
    input wire write,
    input wire waitrequest,
    input wire system_ack,
    input wire enable_switch_active,
    input wire repair_mode_active,
    input wire stop_override,
    input wire stop_timer_cancel,
    input wire repair_stop_sto,
    input wire repair_stop_ss1,
    input wire monitoring_disable,
    input wire cascade_stop,
    input wire [15:0] cascade_delay,
    input wire [1:0] homing_state,
    input wire pos_window_error,
    input wire slip_error,
    input wire safe_output_1
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Bus slave inserts exactly one wait state
    a_wait_first: assert property ($rose(read | write) |-> waitrequest)
        else $error("request answered without wait state");
    a_wait_one: assert property ((read | write) && waitrequest |=> !waitrequest)
        else $error("wait state longer than one cycle");
    // Override and monitoring follow the mode flags
    a_override_follows: assert property (stop_override == enable_switch_active)
        else $error("override differs from switch state");
    a_cancel_leads: assert property (stop_timer_cancel |=> $rose(enable_switch_active))
        else $error("timer cancel not followed by switch rise");
    a_monitor_off: assert property (monitoring_disable == repair_mode_active)
        else $error("monitoring not tied to repair mode");
    a_stop_onehot: assert property (repair_mode_active |-> repair_stop_sto ^ repair_stop_ss1)
        else $error("repair stop selection not exclusive");
    a_homing_cleared: assert property (repair_mode_active |-> homing_state == 2'h0)
        else $error("homing not cleared in repair mode");
    a_error_pair: assert property (pos_window_error == slip_error)
        else $error("window and slip errors differ");
    a_cas_output: assert property ($rose(cascade_stop) |=> !safe_output_1)
        else $error("output one not off after cascade stop");
    // Delay only steps by one or clears on acknowledge
    a_delay_step: assert property (!$stable(cascade_delay) |->
        $past(system_ack) || cascade_delay == $past(cascade_delay) + 16'h0001)
        else $error("cascade delay changed unexpectedly");
    a_delay_sat: assert property (cascade_delay == 16'hFFFF |=>
        cascade_delay == 16'hFFFF || cascade_delay == 16'h0000)
        else $error("cascade delay wrapped");
    // Main scenarios
    cover property ($rose(cascade_stop));
    cover property ($rose(repair_mode_active));
    cover property (stop_timer_cancel);
endmodule // ssoc_chk

bind ssoc_special_ctrl ssoc_chk u_ssoc_chk (.clk, .rst, .read, .write, .waitrequest,
    .system_ack, .enable_switch_active, .repair_mode_active, .stop_override,
    .stop_timer_cancel, .repair_stop_sto, .repair_stop_ss1, .monitoring_disable,
    .cascade_stop, .cascade_delay, .homing_state, .pos_window_error, .slip_error,
    .safe_output_1);

// >>> sim/ssoc_peer.sv
`timescale 1ns/1ps
// ==========================================
// Next drive in the network: output one loops back to input four
module ssoc_peer #(
    parameter LAG = 10
) (
    input wire clk,
    input wire rst,
    input wire safe_output_1,
    input wire ext_stop,
    output wire link_in
);
    reg [LAG-1:0] sh_r;
    // Ten cycles is 1 us at the 10 MHz bench clock, well inside the input delay limit
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sh_r <= {LAG{1'b0}};
        end else begin
            sh_r <= {sh_r[LAG-2:0], safe_output_1};
        end
    end
    // A stop elsewhere in the network pulls the loop off
    assign link_in = sh_r[LAG-1] & ~ext_stop;
endmodule // ssoc_peer

// >>> sim/tb.sv
`timescale 1ns/1ps
`include "ssoc_consts.vh"
// ==========================================
// Bench for the special operation control
module tb;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg [15:0] address = 16'h0000;
    reg read = 1'b0, write = 1'b0;
    reg [31:0] writedata = 32'h0000_0000;
    reg [2:0] sin = 3'h0;
    reg bus_es = 1'b0, bus_rms = 1'b0, bus_so1 = 1'b0, special = 1'b0, safe_torque_off = 1'b0;
    reg ack = 1'b0, absmon = 1'b0, mism = 1'b0, hupd = 1'b0, ext = 1'b0;
    reg [1:0] hval = 2'h0;
    reg [31:0] q;
    reg [15:0] d;
    wire [31:0] readdata;
    wire waitrequest, es_act, rms_act, cas, so1, in4, pwe, slip, ssto, sss1, mdis;
    wire [15:0] dly;
    wire [1:0] hom;
    integer mismatches = 0, compares = 0, cyc = 0;
    ssoc_special_ctrl #(.TICK_CYCLES(4)) u_ssoc_special_ctrl (.clk(clk), .rst(rst),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .safe_input_on({in4, sin}),
        .bus_enable_switch(bus_es), .bus_repair_mode(bus_rms), .bus_safe_output_1(bus_so1),
        .special_op_active(special), .safe_torque_off_req(safe_torque_off), .system_ack(ack),
        .abs_pos_monitor_on(absmon), .encoder_mismatch(mism), .homing_update(hupd),
        .homing_value(hval), .enable_switch_active(es_act), .repair_mode_active(rms_act),
        .stop_override(), .stop_timer_cancel(), .repair_stop_sto(ssto),
        .repair_stop_ss1(sss1), .monitoring_disable(mdis), .cascade_stop(cas),
        .cascade_delay(dly), .homing_state(hom), .pos_window_error(pwe),
        .slip_error(slip), .safe_output_1(so1));
    ssoc_peer #(.LAG(10)) u_ssoc_peer (.clk(clk), .rst(rst), .safe_output_1(so1),
        .ext_stop(ext), .link_in(in4));
    // ==========================================
    // Clock and hang guard
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 30000) begin
            mismatches = mismatches + 1;
            summarize;
        end
    end
    // ==========================================
    // Shared tasks
    task summarize;
        begin
            if (mismatches == 0 && compares > 0) $display("No errors found");
            else $display("Errors were found");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("[ERR] %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task tick(input integer n);
        begin
            repeat (n) @(posedge clk);
        end
    endtask
    // One Avalon access, called right after a rising edge; the request holds
    // until the edge that samples waitrequest low, one idle edge follows
    task bus(input w, input [13:0] i, input [31:0] wd);
        begin
            address <= {i, 2'b00};
            write <= w;
            read <= !w;
            writedata <= wd;
            @(posedge clk);
            while (waitrequest)
                @(posedge clk);
            q = readdata;
            read <= 1'b0;
            write <= 1'b0;
            @(posedge clk);
        end
    endtask
    task pulse_ack;
        begin
            @(posedge clk) ack <= 1'b1;
            @(posedge clk) ack <= 1'b0;
        end
    endtask
    // ==========================================
    // Scenarios
    task t_regs;
        begin
            bus(0, `SSOC_IDX_ES_SRC, 0);
            chk(q, 32'h0000_0000);
            bus(0, 14'h0010, 0);
            chk(q, 32'h0000_0000);
            bus(1, `SSOC_IDX_CAS_DELAY, 32'h0000_0005);
            bus(0, `SSOC_IDX_CAS_DELAY, 0);
            chk(q, 32'h0000_0000);
            bus(1, `SSOC_IDX_ES_SRC, 32'h0000_000D);
            bus(0, `SSOC_IDX_ES_SRC, 0);
            chk(q, 32'h0000_000D);
        end
    endtask
    task t_es;
        begin
            @(posedge clk) special <= 1'b1;
            bus_es <= 1'b1;
            tick(3);
            chk(es_act, 1);
            bus(1, `SSOC_IDX_ES_SRC, 32'h0000_0001);
            tick(3);
            chk(es_act, 0);
            bus_es <= 1'b0;
            @(posedge clk) sin[0] <= 1'b1;
            tick(4);
            chk(es_act, 1);
            bus(1, `SSOC_IDX_ES_OUT, 32'h0000_0001);
            tick(2);
            chk(so1, 1);
            bus(1, `SSOC_IDX_ES_OUT, 32'h0000_0002);
            tick(2);
            chk(so1, 0);
            @(posedge clk) special <= 1'b0;
            bus_es <= 1'b0;
            tick(3);
            chk(es_act, 0);
            chk(so1, 1);
            sin[0] <= 1'b0;
            bus(1, `SSOC_IDX_ES_OUT, 32'h0000_0000);
        end
    endtask
    task t_rms;
        begin
            @(posedge clk) hupd <= 1'b1;
            hval <= 2'h2;
            @(posedge clk) hupd <= 1'b0;
            tick(1);
            chk(hom, `SSOC_HOM_AVAIL);
            bus(1, `SSOC_IDX_RMS_SRC, 32'h0000_0002);
            @(posedge clk) sin[1] <= 1'b1;
            tick(4);
            chk(rms_act, 1);
            chk(mdis, 1);
            chk(hom, `SSOC_HOM_NONE);
            bus(1, `SSOC_IDX_RMS_STOP, 32'h0000_0001);
            chk({ssto, sss1}, 2'b01);
            bus(1, `SSOC_IDX_RMS_STOP, 32'h0000_0000);
            chk({ssto, sss1}, 2'b10);
            @(posedge clk) sin[1] <= 1'b0;
            bus_rms <= 1'b1;
            tick(4);
            chk(rms_act, 0);
            bus(1, `SSOC_IDX_RMS_SRC, 32'h0000_000D);
            tick(2);
            chk(rms_act, 1);
            @(posedge clk) absmon <= 1'b1;
            bus_rms <= 1'b0;
            tick(2);
            @(posedge clk) hupd <= 1'b1;
            hval <= 2'h2;
            @(posedge clk) hupd <= 1'b0;
            mism <= 1'b1;
            tick(3);
            chk({pwe, slip, hom}, 4'b1100);
            @(posedge clk) mism <= 1'b0;
            pulse_ack;
            tick(2);
            chk({pwe, slip}, 2'b00);
        end
    endtask
    // Restart acknowledged and stop two assumed set in the drive
    task t_cas;
        begin
            @(posedge clk) bus_so1 <= 1'b1;
            tick(15);
            bus(1, `SSOC_IDX_CAS_SRC, `SSOC_SRC_IN4);
            @(posedge clk) bus_so1 <= 1'b0;
            tick(3);
            chk(so1, 1);
            @(posedge clk) special <= 1'b1;
            sin[0] <= 1'b1;
            tick(4);
            chk({es_act, cas}, 2'b10);
            @(posedge clk) special <= 1'b0;
            sin[0] <= 1'b0;
            safe_torque_off <= 1'b1;
            tick(30);
            chk(cas, 1);
            chk(dly >= 16'h0002 && dly <= 16'h0004, 1);
            d = dly;
            tick(20);
            chk(dly, d);
            @(posedge clk) safe_torque_off <= 1'b0;
            pulse_ack;
            tick(2);
            chk({so1, dly}, 17'h1_0000);
            tick(20);
            @(posedge clk) ext <= 1'b1;
            tick(6);
            chk(cas, 1);
            tick(20);
            chk(dly, 16'h0000);
            @(posedge clk) ext <= 1'b0;
            pulse_ack;
        end
    endtask
    // ==========================================
    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_es;
        t_rms;
        t_cas;
        summarize;
    end
endmodule // tb
